//--- inc/res_pkg.sv
package res_pkg;
	// Clock and documented timing limits
	localparam int CLK_HZ           = 40_000_000;
	localparam int POR_MAX_MS       = 110;
	localparam int POR_MAX_CYC      = POR_MAX_MS * (CLK_HZ / 1000);
	localparam int SETTLE_MAX_MS    = 40;
	localparam int SETTLE_MAX_CYC   = SETTLE_MAX_MS * (CLK_HZ / 1000);
	localparam int CTS_RTS_MAX_MS   = 10;
	localparam int CTS_RTS_MAX_CYC  = CTS_RTS_MAX_MS * (CLK_HZ / 1000);
	// Serial link bit timing
	localparam int BAUD_RATE        = 115_200;
	localparam int BIT_CYC          = CLK_HZ / BAUD_RATE;
	localparam int HALF_BIT_CYC     = BIT_CYC / 2;
	localparam int TX_START_MAX_CYC = (BIT_CYC * 3) / 2;
	localparam int RTS_STOP_MAX_CYC = BIT_CYC / 2;
	localparam int FRAME_BITS       = 10;
	localparam int STOP_IDX         = FRAME_BITS - 1;
	// Widths
	localparam int TMR_W            = 23;
	localparam int BAUD_W           = 9;
	localparam int IDX_W            = 4;
	// Pin synchroniser layout and idle levels
	localparam int SYNC_W           = 5;
	localparam int SY_WLAN          = 0;
	localparam int SY_RADIO2        = 1;
	localparam int SY_IO            = 2;
	localparam int SY_CTS_N         = 3;
	localparam int SY_RX            = 4;
	localparam logic [SYNC_W-1:0] SYNC_RST = 5'h18;

	typedef enum logic [1:0] {
		w_off,
		w_por,
		w_run
	} res_wlan_st_t;

	typedef enum logic [1:0] {
		r2_off,
		r2_settle,
		r2_wait_cts,
		r2_link
	} res_r2_st_t;

	typedef struct packed {
		logic tx;
		logic tx_oe;
		logic rts_n;
		logic rts_n_oe;
	} res_pins_t;

	localparam res_pins_t PINS_RST = 4'h0;
endpackage : res_pkg

//--- hw/res_uart_link.sv
`timescale 1ns/1ps
module res_uart_link (
	input  wire logic          clock_i,
	input  wire logic          rst_i,
	input  wire logic          pins_en_i,
	input  wire logic          link_en_i,
	input  wire logic          cts_n_i,
	input  wire logic          rx_i,
	input  wire logic          rx_hold_i,
	input  wire logic          tx_valid_i,
	input  wire logic [7:0]    tx_data_i,
	output logic               tx_ready_o,
	output logic               rx_valid_o,
	output logic [7:0]         rx_data_o,
	output res_pkg::res_pins_t pins_o
);
	localparam int TxMax  = res_pkg::TX_START_MAX_CYC;
	localparam int RtsMax = res_pkg::RTS_STOP_MAX_CYC;
	localparam logic [res_pkg::BAUD_W-1:0] BitEnd =
		res_pkg::BAUD_W'(res_pkg::BIT_CYC - 1);
	localparam logic [res_pkg::BAUD_W-1:0] HalfEnd =
		res_pkg::BAUD_W'(res_pkg::HALF_BIT_CYC - 1);
	localparam logic [res_pkg::IDX_W-1:0] StopIdx =
		res_pkg::IDX_W'(res_pkg::STOP_IDX);

	logic                        tx_busy_q, tx_busy_d, tx_rdy_q, tx_rdy_d;
	logic [9:0]                  tx_sh_q, tx_sh_d;
	logic [res_pkg::IDX_W-1:0]   tx_idx_q, tx_idx_d, rx_idx_q, rx_idx_d;
	logic [res_pkg::BAUD_W-1:0]  tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
	logic                        rx_busy_q, rx_busy_d, rx_vld_q, rx_vld_d;
	logic [7:0]                  rx_sh_q, rx_sh_d, rx_dat_q, rx_dat_d;
	logic                        rts_q, rts_d, rx_tick;
	res_pkg::res_pins_t          pins_q, pins_d;

	// Transmitter: a character starts only while clear-to-send is low
	always_comb begin
		tx_busy_d = tx_busy_q;
		tx_sh_d   = tx_sh_q;
		tx_idx_d  = tx_idx_q;
		tx_cnt_d  = tx_cnt_q;
		if (!tx_busy_q) begin
			if (tx_valid_i && tx_rdy_q) begin
				tx_busy_d = 1'b1;
				tx_sh_d   = {1'b1, tx_data_i, 1'b0};
				tx_idx_d  = '0;
				tx_cnt_d  = '0;
			end
		end else if (tx_cnt_q == BitEnd) begin
			tx_cnt_d = '0;
			tx_sh_d  = {1'b1, tx_sh_q[9:1]};
			if (tx_idx_q == StopIdx)
				tx_busy_d = 1'b0;
			else
				tx_idx_d = tx_idx_q + 1'b1;
		end else begin
			tx_cnt_d = tx_cnt_q + 1'b1;
		end
		if (!link_en_i)
			tx_busy_d = 1'b0;
		// Flow stop takes effect only at the next character boundary
		tx_rdy_d = !tx_busy_d && link_en_i && !cts_n_i;
	end

	// Receiver: samples each bit mid-cell, flow decision at stop midpoint
	assign rx_tick = (rx_cnt_q == ((rx_idx_q == '0) ? HalfEnd : BitEnd));

	always_comb begin
		rx_busy_d = rx_busy_q;
		rx_idx_d  = rx_idx_q;
		rx_cnt_d  = rx_cnt_q;
		rx_sh_d   = rx_sh_q;
		rx_dat_d  = rx_dat_q;
		rx_vld_d  = 1'b0;
		rts_d     = rx_busy_q ? rts_q : rx_hold_i;
		if (!rx_busy_q) begin
			if (!rx_i && link_en_i) begin
				rx_busy_d = 1'b1;
				rx_idx_d  = '0;
				rx_cnt_d  = '0;
			end
		end else if (rx_tick) begin
			rx_cnt_d = '0;
			if (rx_idx_q == '0) begin
				rx_busy_d = !rx_i;
				rx_idx_d  = 4'h1;
			end else if (rx_idx_q != StopIdx) begin
				rx_sh_d  = {rx_i, rx_sh_q[7:1]};
				rx_idx_d = rx_idx_q + 1'b1;
			end else begin
				rx_busy_d = 1'b0;
				rx_vld_d  = rx_i;
				rx_dat_d  = rx_i ? rx_sh_q : rx_dat_q;
				rts_d     = rx_hold_i;
			end
		end else begin
			rx_cnt_d = rx_cnt_q + 1'b1;
		end
		if (!link_en_i)
			rx_busy_d = 1'b0;
	end

	// Pin drivers: released whenever the radio pins are not enabled
	always_comb begin
		pins_d.tx       = (link_en_i && tx_busy_d) ? tx_sh_d[0] : 1'b1;
		pins_d.tx_oe    = pins_en_i;
		pins_d.rts_n    = link_en_i ? rts_d : 1'b1;
		pins_d.rts_n_oe = pins_en_i;
	end

	// State registers
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			tx_busy_q <= 1'b0;
			tx_rdy_q  <= 1'b0;
			tx_sh_q   <= '1;
			tx_idx_q  <= '0;
			tx_cnt_q  <= '0;
			rx_busy_q <= 1'b0;
			rx_idx_q  <= '0;
			rx_cnt_q  <= '0;
			rx_sh_q   <= '0;
			rx_dat_q  <= '0;
			rx_vld_q  <= 1'b0;
			rts_q     <= 1'b1;
			pins_q    <= res_pkg::PINS_RST;
		end else begin
			tx_busy_q <= tx_busy_d;
			tx_rdy_q  <= tx_rdy_d;
			tx_sh_q   <= tx_sh_d;
			tx_idx_q  <= tx_idx_d;
			tx_cnt_q  <= tx_cnt_d;
			rx_busy_q <= rx_busy_d;
			rx_idx_q  <= rx_idx_d;
			rx_cnt_q  <= rx_cnt_d;
			rx_sh_q   <= rx_sh_d;
			rx_dat_q  <= rx_dat_d;
			rx_vld_q  <= rx_vld_d;
			rts_q     <= rts_d;
			pins_q    <= pins_d;
		end
	end

	assign tx_ready_o = tx_rdy_q;
	assign rx_valid_o = rx_vld_q;
	assign rx_data_o  = rx_dat_q;
	assign pins_o     = pins_q;

	property p_cts_to_txd;
		@(posedge clock_i) disable iff (rst_i)
		(link_en_i && !cts_n_i && tx_valid_i && !tx_busy_q && !tx_rdy_q)
			|-> ##[1:TxMax] !pins_q.tx;
	endproperty
	a_cts_to_txd: assert property (p_cts_to_txd)
		else $error("Transmit did not start after clear-to-send");

	property p_stop_to_rts;
		@(posedge clock_i) disable iff (rst_i)
		(link_en_i && rx_busy_q && rx_tick && rx_idx_q == StopIdx &&
			rx_hold_i) |-> ##[1:RtsMax] pins_q.rts_n;
	endproperty
	a_stop_to_rts: assert property (p_stop_to_rts)
		else $error("Request-to-send not raised after stop midpoint");
endmodule : res_uart_link

//--- hw/res_sequencer.sv
`timescale 1ns/1ps
module res_sequencer #(
	parameter int POR_CYCLES    = res_pkg::POR_MAX_CYC,
	parameter int SETTLE_CYCLES = res_pkg::SETTLE_MAX_CYC
) (
	input  wire logic          clock_i,
	input  wire logic          rst_i,
	input  wire logic          wlan_power_enable_i,
	input  wire logic          radio2_power_enable_i,
	input  wire logic          io_rail_supply_i,
	input  wire logic          uart_cts_n_i,
	input  wire logic          uart_rx_i,
	input  wire logic          rx_hold_i,
	input  wire logic          tx_valid_i,
	input  wire logic [7:0]    tx_data_i,
	output logic               wlan_core_reset_o,
	output logic               radio2_ready_o,
	output logic               tx_ready_o,
	output logic               rx_valid_o,
	output logic [7:0]         rx_data_o,
	output res_pkg::res_pins_t uart_pins_o
);
	localparam logic [res_pkg::TMR_W-1:0] PorEnd =
		res_pkg::TMR_W'(POR_CYCLES - 1);
	localparam logic [res_pkg::TMR_W-1:0] SettleEnd =
		res_pkg::TMR_W'(SETTLE_CYCLES - 1);

	logic [res_pkg::SYNC_W-1:0] pin_raw, sync1_q, sync2_q;
	logic                       wl_en, r2_en, io_ok, cts_n, rx_s;
	res_pkg::res_wlan_st_t      wl_st_q, wl_st_d;
	res_pkg::res_r2_st_t        r2_st_q, r2_st_d;
	logic [res_pkg::TMR_W-1:0]  wl_cnt_q, wl_cnt_d, r2_cnt_q, r2_cnt_d;
	logic                       core_rst_q, core_rst_d, rdy_q, rdy_d;
	logic                       pins_en_q, pins_en_d, link_en_q, link_en_d;

	// Every pin input passes two flip-flops before use
	assign pin_raw = {uart_rx_i, uart_cts_n_i, io_rail_supply_i,
		radio2_power_enable_i, wlan_power_enable_i};

	genvar gi;
	generate
		for (gi = 0; gi < res_pkg::SYNC_W; gi++) begin : g_sync
			always_ff @(posedge clock_i) begin
				if (rst_i) begin
					sync1_q[gi] <= res_pkg::SYNC_RST[gi];
					sync2_q[gi] <= res_pkg::SYNC_RST[gi];
				end else begin
					sync1_q[gi] <= pin_raw[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	assign wl_en = sync2_q[res_pkg::SY_WLAN];
	assign r2_en = sync2_q[res_pkg::SY_RADIO2];
	assign io_ok = sync2_q[res_pkg::SY_IO];
	assign cts_n = sync2_q[res_pkg::SY_CTS_N];
	assign rx_s  = sync2_q[res_pkg::SY_RX];

	// Wireless core: power-on reset hold, restarted whenever enable drops
	always_comb begin
		wl_st_d  = wl_st_q;
		wl_cnt_d = wl_cnt_q;
		case (wl_st_q)
			res_pkg::w_off: begin
				wl_cnt_d = '0;
				if (wl_en && io_ok)
					wl_st_d = res_pkg::w_por;
			end
			res_pkg::w_por: begin
				if (wl_cnt_q == PorEnd)
					wl_st_d = res_pkg::w_run;
				else
					wl_cnt_d = wl_cnt_q + 1'b1;
			end
			res_pkg::w_run: wl_st_d = res_pkg::w_run;
			default: wl_st_d = res_pkg::w_off;
		endcase
		// Enable low or rail lost aborts at once; a new rise is a full restart
		if (!wl_en || !io_ok) begin
			wl_st_d  = res_pkg::w_off;
			wl_cnt_d = '0;
		end
		core_rst_d = (wl_st_d != res_pkg::w_run);
	end

	// Short-range radio: settle pins, wait for clear-to-send, then link up
	always_comb begin
		r2_st_d  = r2_st_q;
		r2_cnt_d = r2_cnt_q;
		case (r2_st_q)
			res_pkg::r2_off: begin
				r2_cnt_d = '0;
				if (r2_en && io_ok)
					r2_st_d = res_pkg::r2_settle;
			end
			res_pkg::r2_settle: begin
				if (r2_cnt_q == SettleEnd)
					r2_st_d = res_pkg::r2_wait_cts;
				else
					r2_cnt_d = r2_cnt_q + 1'b1;
			end
			res_pkg::r2_wait_cts: begin
				if (!cts_n)
					r2_st_d = res_pkg::r2_link;
			end
			res_pkg::r2_link: r2_st_d = res_pkg::r2_link;
			default: r2_st_d = res_pkg::r2_off;
		endcase
		// Each radio follows only its own enable and the I/O rail
		if (!r2_en || !io_ok) begin
			r2_st_d  = res_pkg::r2_off;
			r2_cnt_d = '0;
		end
		pins_en_d = (r2_st_d == res_pkg::r2_wait_cts) ||
			(r2_st_d == res_pkg::r2_link);
		link_en_d = (r2_st_d == res_pkg::r2_link);
		rdy_d     = link_en_d;
	end

	// State registers
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			wl_st_q    <= res_pkg::w_off;
			wl_cnt_q   <= '0;
			core_rst_q <= 1'b1;
			r2_st_q    <= res_pkg::r2_off;
			r2_cnt_q   <= '0;
			pins_en_q  <= 1'b0;
			link_en_q  <= 1'b0;
			rdy_q      <= 1'b0;
		end else begin
			wl_st_q    <= wl_st_d;
			wl_cnt_q   <= wl_cnt_d;
			core_rst_q <= core_rst_d;
			r2_st_q    <= r2_st_d;
			r2_cnt_q   <= r2_cnt_d;
			pins_en_q  <= pins_en_d;
			link_en_q  <= link_en_d;
			rdy_q      <= rdy_d;
		end
	end

	// Serial link with character-level flow control
	res_uart_link u_link (
		.clock_i    (clock_i),
		.rst_i      (rst_i),
		.pins_en_i  (pins_en_q),
		.link_en_i  (link_en_q),
		.cts_n_i    (cts_n),
		.rx_i       (rx_s),
		.rx_hold_i  (rx_hold_i),
		.tx_valid_i (tx_valid_i),
		.tx_data_i  (tx_data_i),
		.tx_ready_o (tx_ready_o),
		.rx_valid_o (rx_valid_o),
		.rx_data_o  (rx_data_o),
		.pins_o     (uart_pins_o)
	);

	assign wlan_core_reset_o = core_rst_q;
	assign radio2_ready_o    = rdy_q;

	property p_por_release;
		@(posedge clock_i) disable iff (rst_i)
		(wl_st_q == res_pkg::w_por && wl_cnt_q == PorEnd && wl_en && io_ok)
			|=> !wlan_core_reset_o;
	endproperty
	a_por_release: assert property (p_por_release)
		else $error("Core reset held past power-on limit");

	property p_por_bound;
		@(posedge clock_i) disable iff (rst_i)
		wl_cnt_q <= PorEnd;
	endproperty
	a_por_bound: assert property (p_por_bound)
		else $error("Power-on reset counter overran");

	property p_settle_done;
		@(posedge clock_i) disable iff (rst_i)
		(r2_st_q == res_pkg::r2_settle && r2_cnt_q == SettleEnd && r2_en &&
			io_ok) |=> ##1 (uart_pins_o.tx_oe && uart_pins_o.rts_n_oe);
	endproperty
	a_settle_done: assert property (p_settle_done)
		else $error("Pins not settled at end of settle time");

	property p_settle_bound;
		@(posedge clock_i) disable iff (rst_i)
		r2_cnt_q <= SettleEnd;
	endproperty
	a_settle_bound: assert property (p_settle_bound)
		else $error("Settle counter overran");

	property p_cts_rts;
		@(posedge clock_i) disable iff (rst_i)
		(r2_st_q == res_pkg::r2_wait_cts && !cts_n && r2_en && io_ok &&
			!rx_hold_i) ##1 (r2_en && io_ok && !rx_hold_i)
			|-> ##[1:2] !uart_pins_o.rts_n;
	endproperty
	a_cts_rts: assert property (p_cts_rts)
		else $error("Request-to-send not driven low after clear-to-send");

	property p_powerdown;
		@(posedge clock_i) disable iff (rst_i)
		(!r2_en && !wl_en) [*3] |-> (!uart_pins_o.tx_oe &&
			!uart_pins_o.rts_n_oe && wlan_core_reset_o && !radio2_ready_o);
	endproperty
	a_powerdown: assert property (p_powerdown)
		else $error("Pins driven while both enables low");
endmodule : res_sequencer

//--- bench/res_host_model.sv
`timescale 1ns/1ps
// Behavioural host: supplies, radio enables, flow control and serial lines
module res_host_model #(
	parameter int STAB_CYC = 8
) (
	input  wire logic clock_i,
	input  wire logic tx_line_i,
	output logic      wlan_en_o,
	output logic      radio2_en_o,
	output logic      io_rail_o,
	output logic      cts_n_o,
	output logic      rx_line_o
);
	// Everything off, serial lines idle high
	initial begin
		wlan_en_o = 1'b0;
		radio2_en_o = 1'b0;
		io_rail_o = 1'b0;
		cts_n_o = 1'b1;
		rx_line_o = 1'b1;
	end

	// Rail up, then a wait for the sleep clock to settle
	task automatic power_up();
		@(posedge clock_i);
		io_rail_o <= 1'b1;
		repeat (STAB_CYC) @(posedge clock_i);
	endtask : power_up

	// Each enable is its own active-high control
	task automatic set_en(input logic wl, input logic r2);
		@(posedge clock_i);
		wlan_en_o <= wl;
		radio2_en_o <= r2;
	endtask : set_en

	// Enables fall before the rail; a full cycle is the retry path
	task automatic power_down();
		@(posedge clock_i);
		wlan_en_o <= 1'b0;
		radio2_en_o <= 1'b0;
		cts_n_o <= 1'b1;
		@(posedge clock_i);
		io_rail_o <= 1'b0;
	endtask : power_down

	// Flow control toward the module, changed at the next clock edge, even in the middle of a character
	task automatic set_cts_n(input logic v);
		@(posedge clock_i);
		cts_n_o <= v;
	endtask : set_cts_n

	// One frame: start, eight data bits LSB first, stop
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clock_i);
			rx_line_o <= fr[i];
			repeat (res_pkg::BIT_CYC - 1) @(posedge clock_i);
		end
	endtask : send_byte

	// Waits for a start bit, then samples each bit at its middle
	task automatic recv_byte(output logic [7:0] b, output logic ok,
			output int n);
		ok = 1'b0;
		b = 8'h00;
		n = 0;
		while (tx_line_i !== 1'b0 && n < 4000) begin
			@(posedge clock_i);
			n++;
		end
		repeat (res_pkg::HALF_BIT_CYC) @(posedge clock_i);
		ok = (tx_line_i === 1'b0);
		for (int i = 0; i < 8; i++) begin
			repeat (res_pkg::BIT_CYC) @(posedge clock_i);
			b[i] = tx_line_i;
		end
		repeat (res_pkg::BIT_CYC) @(posedge clock_i);
		ok = ok & (tx_line_i === 1'b1);
	endtask : recv_byte
endmodule : res_host_model

//--- bench/tb_radio_enable_startup_sequencer.sv
`timescale 1ns/1ps
module tb_radio_enable_startup_sequencer;
	localparam int POR_N = 20;
	localparam int SET_N = 20;
	// Host-side wait before the first PCIe access, in clock cycles
	localparam int PCIE_WAIT_N = 150 * (res_pkg::CLK_HZ / 1000);
	logic               clock_i = 1'b0;
	logic               rst_i = 1'b1;
	logic               rx_hold = 1'b0;
	logic               tx_valid = 1'b0;
	logic [7:0]         tx_data = 8'h00;
	logic               wl, r2, io, cts_n, rx, tx_line;
	logic               core_rst, r2_ready, tx_ready, rx_valid;
	logic [7:0]         rx_data;
	res_pkg::res_pins_t pins;
	int                 bad_count = 0;
	int                 check_count = 0;
	int                 n;
	logic [7:0]         b;
	logic               ok;

	always #12.5 clock_i = ~clock_i;
	// Released transmit wire sits at its pull-up level
	assign tx_line = pins.tx_oe ? pins.tx : 1'b1;

	res_host_model host (.clock_i(clock_i), .tx_line_i(tx_line),
		.wlan_en_o(wl), .radio2_en_o(r2), .io_rail_o(io),
		.cts_n_o(cts_n), .rx_line_o(rx));
	res_sequencer #(.POR_CYCLES(POR_N), .SETTLE_CYCLES(SET_N)) dut (
		.clock_i(clock_i), .rst_i(rst_i), .wlan_power_enable_i(wl),
		.radio2_power_enable_i(r2), .io_rail_supply_i(io),
		.uart_cts_n_i(cts_n), .uart_rx_i(rx), .rx_hold_i(rx_hold),
		.tx_valid_i(tx_valid), .tx_data_i(tx_data),
		.wlan_core_reset_o(core_rst), .radio2_ready_o(r2_ready),
		.tx_ready_o(tx_ready), .rx_valid_o(rx_valid),
		.rx_data_o(rx_data), .uart_pins_o(pins));

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	task automatic chk(input string name, input logic [31:0] seen,
			input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			$display("mismatch %s expected %0h seen %0h", name, exp, seen);
			bad_count++;
		end
	endtask : chk

	function automatic logic probe(input int sel);
		case (sel)
			0: probe = ~core_rst;
			1: probe = pins.rts_n_oe;
			2: probe = ~pins.rts_n;
			3: probe = rx_valid;
			default: probe = core_rst;
		endcase
	endfunction : probe

	// Counts edges until the probed output is high, bounded
	task automatic wait_for(input int sel, input int bound, output int cnt);
		cnt = 0;
		do begin
			@(posedge clock_i);
			#1;
			cnt++;
		end while (probe(sel) !== 1'b1 && cnt < bound);
		if (probe(sel) !== 1'b1) begin
			$display("mismatch wait %0d expected 1 seen 0", sel);
			bad_count++;
			test_done();
		end
	endtask : wait_for

	task automatic t_power_down();
		chk("pins_oe", {pins.tx_oe, pins.rts_n_oe}, 2'b00);
		chk("core_rst", core_rst, 1'b1);
		chk("tx_ready", tx_ready, 1'b0);
		$display("test power_down done");
	endtask : t_power_down

	task automatic t_wlan_por();
		host.power_up();
		host.set_en(1'b1, 1'b0);
		wait_for(0, POR_N + 10, n);
		// Two sync stages, one edge into the count, then the full hold
		chk("por_len", n, POR_N + 3);
		chk("pcie_wait", n <= PCIE_WAIT_N, 1'b1);
		chk("pins_r2_off", {pins.tx_oe, pins.rts_n_oe}, 2'b00);
		host.set_en(1'b0, 1'b0);
		wait_for(4, 10, n);
		chk("por_restart", n, 3);
		$display("test wlan_por done");
	endtask : t_wlan_por

	task automatic t_radio2_up();
		host.set_en(1'b0, 1'b1);
		wait_for(1, SET_N + 10, n);
		chk("settle_len", n, SET_N + 4);
		chk("idle_lines", {pins.tx, pins.rts_n, r2_ready}, 3'h6);
		host.set_cts_n(1'b0);
		wait_for(2, 20, n);
		chk("rts_len", n <= res_pkg::CTS_RTS_MAX_CYC, 1'b1);
		chk("rts_edges", n, 4);
		chk("ready", r2_ready, 1'b1);
		$display("test radio2_up done");
	endtask : t_radio2_up

	task automatic t_transmit();
		chk("tx_ready", tx_ready, 1'b1);
		@(posedge clock_i);
		tx_data <= 8'hA5;
		tx_valid <= 1'b1;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (tx_ready !== 1'b1 && n < 50);
		tx_valid <= 1'b0;
		if (tx_ready !== 1'b1) begin
			chk("tx_accept", tx_ready, 1'b1);
			test_done();
		end
		host.recv_byte(b, ok, n);
		chk("tx_start", n <= res_pkg::TX_START_MAX_CYC, 1'b1);
		if (n >= 4000)
			test_done();
		chk("tx_frame", ok, 1'b1);
		chk("tx_byte", b, 8'hA5);
		$display("test transmit done");
	endtask : t_transmit

	task automatic t_receive();
		fork
			host.send_byte(8'h3C);
			begin
				repeat (100) @(posedge clock_i);
				rx_hold <= 1'b1;
				repeat (5) @(posedge clock_i);
				#1;
				chk("rts_frozen", pins.rts_n, 1'b0);
				wait_for(3, 4000, n);
				n = n + 104;
				chk("rts_late", n >= 3296, 1'b1);
				chk("rts_early", n <= 3296 + res_pkg::RTS_STOP_MAX_CYC,
					1'b1);
				chk("rts_stop", pins.rts_n, 1'b1);
				chk("rx_byte", rx_data, 8'h3C);
			end
		join
		rx_hold <= 1'b0;
		$display("test receive done");
	endtask : t_receive

	task automatic t_cts_stop();
		host.set_cts_n(1'b1);
		repeat (4) @(posedge clock_i);
		#1;
		chk("tx_refused", tx_ready, 1'b0);
		chk("link_kept", r2_ready, 1'b1);
		// A byte waits while clear-to-send is high, then goes on its fall
		@(posedge clock_i);
		tx_data <= 8'h5A;
		tx_valid <= 1'b1;
		repeat (20) @(posedge clock_i);
		#1;
		chk("tx_held", tx_line, 1'b1);
		fork
			host.recv_byte(b, ok, n);
			begin
				host.set_cts_n(1'b0);
				repeat (1000) @(posedge clock_i);
				host.set_cts_n(1'b1);
			end
		join
		chk("cts_to_tx", n <= res_pkg::TX_START_MAX_CYC, 1'b1);
		if (n >= 4000)
			test_done();
		chk("cur_frame", ok, 1'b1);
		chk("cur_byte", b, 8'h5A);
		// Valid still high: no second character may start
		repeat (400) @(posedge clock_i);
		#1;
		chk("tx_stopped", tx_ready, 1'b0);
		chk("tx_idle", tx_line, 1'b1);
		@(posedge clock_i);
		tx_valid <= 1'b0;
		$display("test cts_stop done");
	endtask : t_cts_stop

	task automatic t_power_cycle();
		host.power_down();
		repeat (4) @(posedge clock_i);
		#1;
		chk("pins_off", {pins.tx_oe, pins.rts_n_oe}, 2'b00);
		chk("ready_off", r2_ready, 1'b0);
		host.power_up();
		host.set_en(1'b1, 1'b1);
		wait_for(0, POR_N + 10, n);
		chk("por_again", n, POR_N + 3);
		$display("test power_cycle done");
	endtask : t_power_cycle

	// Reset, then the scenarios in order
	initial begin
		repeat (6) @(posedge clock_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		#1;
		t_power_down();
		t_wlan_por();
		t_radio2_up();
		t_transmit();
		t_receive();
		t_cts_stop();
		t_power_cycle();
		test_done();
	end
endmodule : tb_radio_enable_startup_sequencer
